// ---- src/oms_pkg.sv ----
// package of the operational mode sequencer: register map, fields, timing.
// assumes a 100 MHz ref_clk and 32-bit classic wishbone data.
package oms_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, word aligned)
  // ------------------------------------------------------------
  localparam logic [7:0] OMS_MODE_IDX = 8'h03;
  localparam logic [7:0] OMS_MODE_ADDR = 8'h0c;
  localparam logic [7:0] OMS_STAT_ADDR = 8'h20;
  localparam logic [7:0] OMS_FLAG_ADDR = 8'h24;
  localparam logic [7:0] OMS_IEN_ADDR = 8'h28;

  // ------------------------------------------------------------
  // power_mode_control fields
  // ------------------------------------------------------------
  localparam int OMS_B_SLEEP = 0;
  localparam int OMS_B_STANDBY_REQUEST = 1;
  localparam int OMS_B_UNDERVOLTAGE_DRIVER_PROTECT = 2;
  localparam int OMS_B_OVERVOLTAGE_DRIVER_PROTECT = 3;
  localparam int OMS_B_LPWD = 4;
  localparam int OMS_B_SEAC = 5;
  localparam int OMS_B_CPAC = 6;
  localparam logic [7:0] OMS_MODE_RST = 8'h0c;
  localparam logic [7:0] OMS_MODE_RMASK = 8'h7c;

  // ------------------------------------------------------------
  // flag register fields (write one to clear)
  // ------------------------------------------------------------
  localparam int OMS_F_OV = 0;
  localparam int OMS_F_UV = 1;
  localparam int OMS_F_CP = 2;
  localparam int OMS_F_BUS = 3;
  localparam int OMS_F_WD = 4;
  localparam int OMS_NFLAG = 5;
  localparam logic [4:0] OMS_IEN_RST = 5'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int OMS_CLK_MHZ = 100;
  localparam int OMS_STEP_NS = 1000;
  localparam int OMS_STEP_CYC = (OMS_STEP_NS * OMS_CLK_MHZ) / 1000;

  typedef enum logic [2:0] {
    OMS_ST_CHECK, OMS_ST_NORMAL, OMS_ST_SLEEP, OMS_ST_STANDBY,
    OMS_ST_WAKE_ANA, OMS_ST_WAKE_CLK, OMS_ST_WAKE_SUP, OMS_ST_LOCKED
  } oms_state_t;

endpackage

// ---- src/oms_sequencer.sv ----
// operational mode sequencer: normal, sleep and standby control with
// a wishbone slave for the mode register, flags and interrupt enables.
// assumes supply, oscillator, bus and watchdog indications arrive from
// other domains as levels or pulses and are synchronised here.
//
// Summary of operation
// - after reset check supplies, else locked sleep
// - write bit0 one requests sleep
// - write bit1 one requests standby
// - request bits and bit7 read zero
// - both request bits set: whole write ignored
// - sleep: cpu and analog supplies off
// - sleep runs digital logic from slow oscillator
// - failed slow oscillator: sleep request ignored
// - wake: analog up, fast clock, cpu supply
// - recheck supplies before cpu clock, else sleep
// - sleep or standby disables all drivers
// - standby ignored while interrupt line low
// - standby interrupt restores clock, returns normal
// - bus wake detect in low power, flag set
// - lowpower watchdog: standby timeout only wakes
// - lowpower watchdog: sleep timeout wakes; else off
// - bit6 enables pump error flag autoclear
// - bit5 enables supply flag autoclear
// - bit3 overvoltage disables drivers
// - bit2 undervoltage disables drivers
// - interrupt line low on enabled flag
`timescale 1ns/100ps
`default_nettype none

module oms_sequencer
  import oms_pkg::*;
#(
  parameter int STEP_CYC = oms_pkg::OMS_STEP_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // supply and clock status (asynchronous levels)
  input wire logic core_supply_ok,
  input wire logic io_supply_ok,
  input wire logic slow_osc_fail,
  input wire logic overvoltage_in,
  input wire logic undervoltage_in,
  input wire logic pump_error_in,
  // wake sources (asynchronous levels)
  input wire logic bus_wakeup_in,
  input wire logic wd_timeout_in,
  // power and clock controls
  output logic cpu_supply_en,
  output logic analog_supply_en,
  output logic slow_clk_sel,
  output logic cpu_clk_en,
  output logic cpu_reset_n,
  output logic bus_wake_det_en,
  output logic lowpower_wd_run,
  output logic watchdog_reset_en,
  output logic driver_allow,
  output logic interrupt_line_n
);
  import oms_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_reg, sync2_reg;
  wire logic [NSYNC-1:0] async_in = {wd_timeout_in, bus_wakeup_in, pump_error_in,
    undervoltage_in, overvoltage_in, slow_osc_fail, io_supply_ok, core_supply_ok};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire logic supplies_ok = sync2_reg[0] & sync2_reg[1];
  wire logic osc_failed = sync2_reg[2];
  wire logic ov_s = sync2_reg[3];
  wire logic uv_s = sync2_reg[4];
  wire logic cp_s = sync2_reg[5];
  wire logic bus_s = sync2_reg[6];
  wire logic wd_s = sync2_reg[7];

  // ------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg;
  wire logic acc = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr = acc & wb_we_i & wb_sel_i[0];
  wire logic hit_mode = wb_adr_i == OMS_MODE_ADDR;
  wire logic hit_flag = wb_adr_i == OMS_FLAG_ADDR;
  wire logic hit_ien = wb_adr_i == OMS_IEN_ADDR;
  wire logic [7:0] wbyte = wb_dat_i[7:0];
  wire logic both_req = wbyte[OMS_B_SLEEP] & wbyte[OMS_B_STANDBY_REQUEST];
  wire logic mode_wr = wr & hit_mode & ~both_req;
  wire logic flag_wr = wr & hit_flag;
  wire logic ien_wr = wr & hit_ien;

  // ------------------------------------------------------------
  // mode register, flags, enables
  // ------------------------------------------------------------
  logic [7:0] mode_reg, mode_next;
  logic [OMS_NFLAG-1:0] flag_reg, flag_next, ien_reg;
  oms_state_t state_reg, state_next;
  logic sleep_req_reg, standby_request_req_reg;
  logic wd_prev_reg, bus_prev_reg;

  // ------------------------------------------------------------
  // state decodes shared by the flag, output and request logic
  // ------------------------------------------------------------
  // locked counts as sleep for the outputs but takes no wake-up
  function automatic logic oms_is_sleep(input oms_state_t s);
    return s == OMS_ST_SLEEP || s == OMS_ST_LOCKED;
  endfunction

  function automatic logic oms_is_low(input oms_state_t s);
    return s == OMS_ST_SLEEP || s == OMS_ST_STANDBY;
  endfunction

  wire logic in_low = oms_is_low(state_reg);
  wire logic irq_any = |(flag_reg & ien_reg);
  wire logic wd_rise = wd_s & ~wd_prev_reg;
  wire logic bus_rise = bus_s & ~bus_prev_reg;
  // watchdog only counts in low power when enabled
  wire logic wd_event = wd_rise & (~in_low | mode_reg[OMS_B_LPWD]);

  always_comb begin
    mode_next = mode_reg;
    if (mode_wr) begin
      mode_next = (wbyte & OMS_MODE_RMASK) | (mode_reg & ~OMS_MODE_RMASK);
    end
  end

  // set wins over clear; auto clear only once the condition is gone
  always_comb begin
    flag_next = flag_reg;
    if (flag_wr) begin
      flag_next = flag_reg & ~wbyte[OMS_NFLAG-1:0];
    end
    if (mode_reg[OMS_B_SEAC] && !ov_s) begin
      flag_next[OMS_F_OV] = 1'b0;
    end
    if (mode_reg[OMS_B_SEAC] && !uv_s) begin
      flag_next[OMS_F_UV] = 1'b0;
    end
    if (mode_reg[OMS_B_CPAC] && !cp_s) begin
      flag_next[OMS_F_CP] = 1'b0;
    end
    // the sets come last so a clear in the same cycle never hides an event
    if (ov_s) begin
      flag_next[OMS_F_OV] = 1'b1;
    end
    if (uv_s) begin
      flag_next[OMS_F_UV] = 1'b1;
    end
    if (cp_s) begin
      flag_next[OMS_F_CP] = 1'b1;
    end
    if (bus_rise && in_low) begin
      flag_next[OMS_F_BUS] = 1'b1;
    end
    if (wd_event) begin
      flag_next[OMS_F_WD] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // step timer paces the wake sequence
  // ------------------------------------------------------------
  logic [15:0] step_reg;
  wire logic step_done = step_reg == 16'h0000;

  // ------------------------------------------------------------
  // mode state machine
  // ------------------------------------------------------------
  wire logic sleep_ok = sleep_req_reg & ~osc_failed;
  wire logic standby_request_ok = standby_request_req_reg & ~irq_any;
  wire logic sleep_wake = bus_rise | (wd_rise & mode_reg[OMS_B_LPWD]);
  wire logic standby_request_wake = irq_any | bus_rise | (wd_rise & mode_reg[OMS_B_LPWD]);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OMS_ST_CHECK: begin
        if (step_done) begin
          state_next = supplies_ok ? OMS_ST_NORMAL : OMS_ST_LOCKED;
        end
      end
      OMS_ST_NORMAL: begin
        if (sleep_ok) begin
          state_next = OMS_ST_SLEEP;
        end else if (standby_request_ok) begin
          state_next = OMS_ST_STANDBY;
        end
      end
      OMS_ST_SLEEP: begin
        if (sleep_wake) begin
          state_next = OMS_ST_WAKE_ANA;
        end
      end
      OMS_ST_STANDBY: begin
        if (standby_request_wake) begin
          state_next = OMS_ST_NORMAL;
        end
      end
      // each wake step waits a full step time so the rails can settle
      OMS_ST_WAKE_ANA: begin
        if (step_done) begin
          state_next = OMS_ST_WAKE_CLK;
        end
      end
      OMS_ST_WAKE_CLK: begin
        if (step_done) begin
          state_next = OMS_ST_WAKE_SUP;
        end
      end
      OMS_ST_WAKE_SUP: begin
        if (step_done) begin
          state_next = supplies_ok ? OMS_ST_NORMAL : OMS_ST_SLEEP;
        end
      end
      // only a new reset leaves the lockout; no wake source is honoured
      OMS_ST_LOCKED: begin
        state_next = OMS_ST_LOCKED;
      end
      default: begin
        state_next = OMS_ST_CHECK;
      end
    endcase
  end

  wire logic state_change = state_next != state_reg;
  wire logic st_norm = state_next == OMS_ST_NORMAL;
  wire logic st_sleep = oms_is_sleep(state_next);
  wire logic st_standby_request = state_next == OMS_ST_STANDBY;
  wire logic st_lowp = st_sleep | st_standby_request;
  wire logic st_ana = !st_sleep && state_next != OMS_ST_CHECK;
  wire logic st_slow = st_sleep || state_next == OMS_ST_WAKE_ANA;
  wire logic st_cpus = st_norm || st_standby_request || state_next == OMS_ST_WAKE_SUP ||
    state_next == OMS_ST_CHECK;
  wire logic ov_cut = mode_reg[OMS_B_OVERVOLTAGE_DRIVER_PROTECT] & flag_reg[OMS_F_OV];
  wire logic uv_cut = mode_reg[OMS_B_UNDERVOLTAGE_DRIVER_PROTECT] & flag_reg[OMS_F_UV];
  wire logic drv_ok = st_norm & ~ov_cut & ~uv_cut & ~flag_reg[OMS_F_CP];

  // ------------------------------------------------------------
  // read mux; request bits and bit 7 read zero
  // ------------------------------------------------------------
  wire logic [7:0] stat_byte = {3'h0, osc_failed, supplies_ok, state_reg};
  wire logic [7:0] rbyte =
    hit_mode ? (mode_reg & OMS_MODE_RMASK) :
    hit_flag ? {3'h0, flag_reg} :
    hit_ien ? {3'h0, ien_reg} :
    (wb_adr_i == OMS_STAT_ADDR) ? stat_byte : 8'h00;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= acc;
      rdata_reg <= acc ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= OMS_MODE_RST;
      flag_reg <= '0;
      ien_reg <= OMS_IEN_RST;
      wd_prev_reg <= 1'b0;
      bus_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      flag_reg <= flag_next;
      if (ien_wr) begin
        ien_reg <= wbyte[OMS_NFLAG-1:0];
      end
      wd_prev_reg <= wd_s;
      bus_prev_reg <= bus_s;
    end
  end

  // request latches clear when acted upon or when the mode is left
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_req_reg <= 1'b0;
      standby_request_req_reg <= 1'b0;
    end else begin
      if (mode_wr && wbyte[OMS_B_SLEEP]) begin
        sleep_req_reg <= 1'b1;
      end else if (state_reg != OMS_ST_NORMAL || osc_failed) begin
        sleep_req_reg <= 1'b0;
      end
      if (mode_wr && wbyte[OMS_B_STANDBY_REQUEST]) begin
        standby_request_req_reg <= 1'b1;
      end else if (state_reg != OMS_ST_NORMAL || irq_any) begin
        standby_request_req_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= OMS_ST_CHECK;
      step_reg <= 16'(STEP_CYC);
    end else begin
      state_reg <= state_next;
      if (state_change) begin
        step_reg <= 16'(STEP_CYC);
      end else if (!step_done) begin
        step_reg <= step_reg - 16'h0001;
      end
    end
  end

  // outputs all come from flip-flops and follow state_next, so each
  // control changes on the same edge as the state it belongs to.
  // the cpu supply stays on through reset: the start-up check needs
  // the rails up before it can judge them.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_supply_en <= 1'b1;
      analog_supply_en <= 1'b0;
      slow_clk_sel <= 1'b0;
      cpu_clk_en <= 1'b0;
      cpu_reset_n <= 1'b0;
      bus_wake_det_en <= 1'b0;
      lowpower_wd_run <= 1'b0;
      watchdog_reset_en <= 1'b0;
      driver_allow <= 1'b0;
      interrupt_line_n <= 1'b1;
    end else begin
      cpu_supply_en <= st_cpus;
      analog_supply_en <= st_ana;
      slow_clk_sel <= st_slow;
      cpu_clk_en <= st_norm;
      cpu_reset_n <= st_norm | st_standby_request;
      bus_wake_det_en <= st_lowp;
      lowpower_wd_run <= st_lowp & mode_reg[OMS_B_LPWD];
      watchdog_reset_en <= st_norm;
      driver_allow <= drv_ok;
      // built from flag_next so the line drops on the edge the flag sets
      interrupt_line_n <= ~|(flag_next & ien_reg);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

`default_nettype wire

// ---- verification/oms_seq_asserts.sv ----
// port checker for the mode sequencer, bound into oms_sequencer.
// assumes synchronous active-high rst and the ports as declared there.
`timescale 1ns/100ps
`default_nettype none
module oms_seq_asserts
  import oms_pkg::*;
#(
  parameter int STEP_CYC = 100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power and clock controls
  input wire logic cpu_supply_en,
  input wire logic analog_supply_en,
  input wire logic slow_clk_sel,
  input wire logic cpu_clk_en,
  input wire logic cpu_reset_n,
  input wire logic bus_wake_det_en,
  input wire logic lowpower_wd_run,
  input wire logic watchdog_reset_en,
  input wire logic driver_allow,
  input wire logic interrupt_line_n
);
  // standby exit waits for no wake step; the bound still leaves a full step time of margin
  localparam int EXIT_MAX = STEP_CYC + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  chk_mode_rdzero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OMS_MODE_ADDR
    |-> wb_dat_o[7] == 1'b0 && wb_dat_o[1:0] == 2'b00) else $error("mode read not zero");
  chk_lowpower_drv: assert property (bus_wake_det_en |-> !driver_allow)
    else $error("drivers allowed in low power");
  chk_sleep_supply: assert property (slow_clk_sel && !analog_supply_en |-> !cpu_supply_en)
    else $error("cpu supply on in sleep");
  chk_wake_order: assert property ($rose(cpu_supply_en) |-> analog_supply_en && !slow_clk_sel)
    else $error("cpu supply before analog and fast clock");
  chk_fast_clk: assert property ($fell(slow_clk_sel) |-> analog_supply_en && !cpu_supply_en)
    else $error("fast clock out of order");
  chk_cpu_held: assert property (!cpu_supply_en |-> !cpu_clk_en && !cpu_reset_n)
    else $error("cpu clock or reset released without supply");
  chk_standby_request_exit: assert property (bus_wake_det_en && cpu_supply_en && !interrupt_line_n
    |-> ##[0:EXIT_MAX] !bus_wake_det_en) else $error("standby not left on interrupt");
  chk_lp_wdog: assert property (lowpower_wd_run |-> bus_wake_det_en && !watchdog_reset_en)
    else $error("low power watchdog may reset");
endmodule
bind oms_sequencer oms_seq_asserts #(.STEP_CYC(STEP_CYC)) i_oms_seq_asserts (.ref_clk, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .cpu_supply_en,
  .analog_supply_en, .slow_clk_sel, .cpu_clk_en, .cpu_reset_n, .bus_wake_det_en,
  .lowpower_wd_run, .watchdog_reset_en, .driver_allow, .interrupt_line_n);
`default_nettype wire

// ---- verification/oms_cpu_model.sv ----
// processor-side model: rails follow the switched cpu supply, and the
// core halts while its clock is gated until the interrupt line drops.
`timescale 1ns/100ps
`default_nettype none
module oms_cpu_model (
  // clock
  input wire logic ref_clk,
  // from the sequencer
  input wire logic cpu_supply_en,
  input wire logic cpu_clk_en,
  input wire logic interrupt_line_n,
  // bench control
  input wire logic supply_fault,
  // to the sequencer and bench
  output logic core_supply_ok,
  output logic io_supply_ok,
  output logic halted
);
  // rails collapse at once when the switch opens, no hold-up modelled
  assign core_supply_ok = (cpu_supply_en === 1'b1) && !supply_fault;
  assign io_supply_ok = (cpu_supply_en === 1'b1) && !supply_fault;
  always_ff @(posedge ref_clk) begin
    halted <= !cpu_clk_en && interrupt_line_n;
  end
endmodule
`default_nettype wire

// ---- verification/operational_mode_sequencer_test.sv ----
// self-checking bench for the mode sequencer over classic wishbone.
// assumes a 100 MHz ref_clk and STEP_CYC shortened to 2.
`timescale 1ns/100ps
`default_nettype none
module operational_mode_sequencer_test;
  import oms_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [2:0] flt = 3'h0;
  logic slow_osc_fail = 1'b0, bus_wakeup_in = 1'b0, wd_timeout_in = 1'b0, supply_fault = 1'b0;
  logic wb_ack_o, core_supply_ok, io_supply_ok, cpu_supply_en, analog_supply_en, slow_clk_sel;
  logic cpu_clk_en, cpu_reset_n, bus_wake_det_en, lowpower_wd_run, watchdog_reset_en;
  logic driver_allow, interrupt_line_n, halted;
  int err_count = 0, checks = 0, cyc_n = 0, i;
  oms_sequencer #(.STEP_CYC(2)) i_oms_sequencer (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_supply_ok,
    .io_supply_ok, .slow_osc_fail, .overvoltage_in(flt[0]), .undervoltage_in(flt[1]),
    .pump_error_in(flt[2]), .bus_wakeup_in, .wd_timeout_in, .cpu_supply_en, .analog_supply_en,
    .slow_clk_sel, .cpu_clk_en, .cpu_reset_n, .bus_wake_det_en, .lowpower_wd_run,
    .watchdog_reset_en, .driver_allow, .interrupt_line_n);
  oms_cpu_model i_oms_cpu_model (.ref_clk, .cpu_supply_en, .cpu_clk_en, .interrupt_line_n,
    .supply_fault, .core_supply_ok, .io_supply_ok, .halted);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // bus access and comparison
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // called at a rising edge; returns one edge after release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_st(input logic [2:0] st);
    int n;
    n = 0;
    wb(1'b0, OMS_STAT_ADDR, 32'h0);
    while (rd[2:0] !== st && n < 40) begin
      wb(1'b0, OMS_STAT_ADDR, 32'h0);
      n++;
    end
    chk({29'h0, rd[2:0]}, {29'h0, st});
  endtask
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    wait_st(3'd1);
    rdc(OMS_MODE_ADDR, 32'h0c);
    rdc(8'h40, 32'h0);
    wb(1'b1, OMS_MODE_ADDR, 32'h73);
    rdc(OMS_MODE_ADDR, 32'h0c);
    wb(1'b1, OMS_MODE_ADDR, 32'hf0);
    rdc(OMS_MODE_ADDR, 32'h70);
    wb(1'b1, OMS_IEN_ADDR, 32'h1f);
    rdc(OMS_IEN_ADDR, 32'h1f);
    $display("test registers done");
    wb(1'b1, OMS_MODE_ADDR, 32'h6c);
    for (i = 0; i < 3; i++) begin
      flt[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chb(driver_allow, 1'b0);
      chb(interrupt_line_n, 1'b0);
      flt[i] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rdc(OMS_FLAG_ADDR, 32'h0);
      chb(driver_allow, 1'b1);
    end
    wb(1'b1, OMS_MODE_ADDR, 32'h00);
    for (i = 0; i < 2; i++) begin
      flt[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chb(driver_allow, 1'b1);
      wb(1'b1, OMS_MODE_ADDR, 32'h02);
      repeat (4) @(posedge ref_clk);
      rdc(OMS_STAT_ADDR, 32'h09);
      flt[i] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rdc(OMS_FLAG_ADDR, 32'(1) << i);
      wb(1'b1, OMS_FLAG_ADDR, 32'h1f);
    end
    $display("test faults done");
    wb(1'b1, OMS_MODE_ADDR, 32'h12);
    wait_st(3'd3);
    chb(driver_allow, 1'b0);
    chb(halted, 1'b1);
    chb(bus_wake_det_en, 1'b1);
    chb(watchdog_reset_en, 1'b0);
    bus_wakeup_in <= 1'b1;
    wait_st(3'd1);
    rdc(OMS_FLAG_ADDR, 32'h08);
    bus_wakeup_in <= 1'b0;
    wb(1'b1, OMS_FLAG_ADDR, 32'h1f);
    wb(1'b1, OMS_MODE_ADDR, 32'h12);
    wait_st(3'd3);
    wd_timeout_in <= 1'b1;
    wait_st(3'd1);
    chb(cpu_reset_n, 1'b1);
    wd_timeout_in <= 1'b0;
    wb(1'b1, OMS_FLAG_ADDR, 32'h1f);
    $display("test standby done");
    wb(1'b1, OMS_MODE_ADDR, 32'h11);
    wait_st(3'd2);
    chk({29'h0, cpu_supply_en, analog_supply_en, slow_clk_sel}, 32'h1);
    chb(lowpower_wd_run, 1'b1);
    wd_timeout_in <= 1'b1;
    wait_st(3'd1);
    chk({30'h0, cpu_clk_en, slow_clk_sel}, 32'h2);
    chb(driver_allow, 1'b1);
    wd_timeout_in <= 1'b0;
    wb(1'b1, OMS_FLAG_ADDR, 32'h1f);
    wb(1'b1, OMS_MODE_ADDR, 32'h01);
    wait_st(3'd2);
    chb(lowpower_wd_run, 1'b0);
    wd_timeout_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wait_st(3'd2);
    wd_timeout_in <= 1'b0;
    supply_fault <= 1'b1;
    bus_wakeup_in <= 1'b1;
    repeat (40) @(posedge ref_clk);
    wait_st(3'd2);
    chb(cpu_reset_n, 1'b0);
    bus_wakeup_in <= 1'b0;
    supply_fault <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus_wakeup_in <= 1'b1;
    wait_st(3'd1);
    bus_wakeup_in <= 1'b0;
    wb(1'b1, OMS_FLAG_ADDR, 32'h1f);
    $display("test sleep done");
    slow_osc_fail <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b1, OMS_MODE_ADDR, 32'h01);
    repeat (6) @(posedge ref_clk);
    rdc(OMS_STAT_ADDR, 32'h19);
    supply_fault <= 1'b1;
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    wait_st(3'd7);
    chb(cpu_reset_n, 1'b0);
    $display("test lockout done");
    wrap_up();
  end
endmodule
`default_nettype wire
